// ==== optcfg_pkg.sv ====
/*
 Package for the reset/clock option byte loader: register map, field positions,
 reset-wait counts and packed carriers.
 Assumes a 20 MHz system clock and a precision oscillator tick supplied as a pin.
*/
package optcfg_pkg;
   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [7:0] OPT_BYTE_INDEX = 8'h01;  // Printed offset (index)
   localparam logic [7:0] OPT_BYTE_ADDR  = 8'h04;  // Byte address, index times four
   localparam logic [7:0] CTRL_ADDR      = 8'h08;  // Flash grant and blocked status
   localparam logic [7:0] STAT_ADDR      = 8'h0C;  // Decoded state readback
   // ----------------------------------------------------------------------
   // Option byte fields
   // ----------------------------------------------------------------------
   localparam int WAIT_MSB  = 7;
   localparam int WAIT_LSB  = 6;
   localparam int GUARD_BIT = 5;
   localparam int MAIN_BIT  = 4;
   localparam int AUX_TYPE  = 1;
   localparam int AUX_BIT   = 0;
   localparam logic [7:0] OPT_MASK  = 8'hF3;  // Reserved bits 3:2 read zero
   localparam logic [7:0] OPT_RESET = 8'h00;
   // ----------------------------------------------------------------------
   // Reset wait counts in precision oscillator cycles
   // ----------------------------------------------------------------------
   localparam logic [13:0] WAIT_500   = 14'd500;
   localparam logic [13:0] WAIT_1000  = 14'd1000;
   localparam logic [13:0] WAIT_5000  = 14'd5000;
   localparam logic [13:0] WAIT_10000 = 14'd10000;
   // ----------------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [1:0] wait_sel;
      logic       guard_on;
      logic       main_off;
      logic       aux_type;
      logic       aux_off;
   } opt_cfg_t;
   typedef struct packed {
      logic main_xtal_en;
      logic aux_osc_en;
      logic aux_xtal_mode;
   } osc_ctl_t;
endpackage : optcfg_pkg

// ==== flash_option_reset_config.sv ====
/*
 Option byte loader: latches the option byte at reset, times the reset wait,
 steers oscillators during reset and gates flash program/erase requests.
 Assumes the flash word, low-voltage flag and oscillator tick come from outside
 the clock domain; the bus master follows AXI4-Lite.
*/
// How it works
// - Wait field picks 500/1000/5000/10000 oscillator cycles
// - Guard bit blocks flash writes under low voltage
// - Main bit zero keeps crystal running in reset
// - Main bit one holds crystal off in reset
// - Main bit never selects system clock source
// - Aux type bit selects clock input or crystal
// - Aux bit zero keeps aux oscillator on in reset
// - Aux bit one turns aux oscillator off in reset
// - Flash writes need option guard and other locks
`timescale 1ns/1ns
module flash_option_reset_config
(
   input  wire logic                  i_clk,
   input  wire logic                  i_rst,
   input  wire logic [7:0]            i_flash_opt_byte,
   input  wire logic                  i_osc_tick,
   input  wire logic                  i_low_voltage,
   input  wire logic                  i_flash_req,
   input  wire logic                  i_ctl_unlocked,
   input  wire logic                  i_sector_open,
   input  wire logic                  i_awvalid,
   output logic                       o_awready,
   input  wire logic [7:0]            i_awaddr,
   input  wire logic                  i_wvalid,
   output logic                       o_wready,
   input  wire logic [31:0]           i_wdata,
   input  wire logic [3:0]            i_wstrb,
   output logic                       o_bvalid,
   input  wire logic                  i_bready,
   output logic [1:0]                 o_bresp,
   input  wire logic                  i_arvalid,
   output logic                       o_arready,
   input  wire logic [7:0]            i_araddr,
   output logic                       o_rvalid,
   input  wire logic                  i_rready,
   output logic [31:0]                o_rdata,
   output logic [1:0]                 o_rresp,
   output logic                       o_sys_reset,
   output optcfg_pkg::osc_ctl_t       o_osc,
   output logic                       o_flash_grant,
   output logic                       o_flash_blocked
);
   typedef enum logic [1:0] {LOAD, WAIT, RUN} phase_t;

   phase_t                 phase_q;
   optcfg_pkg::opt_cfg_t   cfg_q;
   logic [13:0]            cnt_q;
   logic [13:0]            target;
   logic [2:0]             tick_s_q;
   logic [1:0]             lv_s_q;
   logic [7:0]             opt_s1_q;
   logic [7:0]             opt_s2_q;
   logic                   tick_rise;
   logic                   blocked;
   logic                   aw_q;
   logic                   w_q;
   logic [7:0]             awaddr_q;
   logic [31:0]            wdata_q;
   logic [3:0]             wstrb_q;

   // ----------------------------------------------------------------------
   // Synchronisers
   // ----------------------------------------------------------------------
   // Two flops on every outside input; third tick stage only for edge detect
   always_ff @(posedge i_clk)
   begin
      tick_s_q <= {tick_s_q[1:0], i_osc_tick};
      lv_s_q   <= {lv_s_q[0], i_low_voltage};
      opt_s1_q <= i_flash_opt_byte;
      opt_s2_q <= opt_s1_q;
   end
   assign tick_rise = tick_s_q[1] & ~tick_s_q[2];

   // ----------------------------------------------------------------------
   // Reset sequence
   // ----------------------------------------------------------------------
   // Select the wait length from the latched field
   always_comb
   begin
      unique case (cfg_q.wait_sel)
         2'b00:   target = optcfg_pkg::WAIT_500;
         2'b01:   target = optcfg_pkg::WAIT_1000;
         2'b10:   target = optcfg_pkg::WAIT_5000;
         2'b11:   target = optcfg_pkg::WAIT_10000;
      endcase
   end

   // Latch the byte once, then count oscillator ticks before release
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         phase_q <= LOAD;
         cfg_q   <= '0;
         cnt_q   <= '0;
      end
      else
      begin
         unique case (phase_q)
            LOAD:
            begin
               cfg_q   <= optcfg_pkg::opt_cfg_t'({opt_s2_q[7:4], opt_s2_q[1:0]});
               cnt_q   <= '0;
               phase_q <= WAIT;
            end
            WAIT:
            begin
               if (tick_rise)
               begin
                  cnt_q <= cnt_q + 14'd1;
                  if (cnt_q + 14'd1 >= target)
                     phase_q <= RUN;
               end
            end
            RUN:
            begin
               phase_q <= RUN;
            end
         endcase
      end
   end

   // Reset output and oscillator enables during reset
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_sys_reset <= 1'b1;
         o_osc       <= '0;
      end
      else
      begin
         o_sys_reset        <= (phase_q != RUN);
         // Main bit affects only the reset period; clock select lives elsewhere
         o_osc.main_xtal_en <= (phase_q == RUN) | ~cfg_q.main_off;
         o_osc.aux_osc_en   <= (phase_q == RUN) | ~cfg_q.aux_off;
         o_osc.aux_xtal_mode <= cfg_q.aux_type;
      end
   end

   // ----------------------------------------------------------------------
   // Flash program/erase gating
   // ----------------------------------------------------------------------
   assign blocked = cfg_q.guard_on & lv_s_q[1];
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_flash_grant   <= 1'b0;
         o_flash_blocked <= 1'b0;
      end
      else
      begin
         o_flash_blocked <= blocked;
         o_flash_grant   <= i_flash_req & (phase_q == RUN) & ~blocked
                            & i_ctl_unlocked & i_sector_open;
      end
   end

   // ----------------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------------
   // Write: take address and data in any order, answer when both are held
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         aw_q      <= 1'b0;
         w_q       <= 1'b0;
         o_awready <= 1'b1;
         o_wready  <= 1'b1;
         o_bvalid  <= 1'b0;
         o_bresp   <= 2'b00;
         awaddr_q <= '0;
         wdata_q  <= '0;
         wstrb_q  <= '0;
      end
      else
      begin
         if (i_awvalid & o_awready)
         begin
            aw_q      <= 1'b1;
            o_awready <= 1'b0;
            awaddr_q  <= i_awaddr;
         end
         if (i_wvalid & o_wready)
         begin
            w_q      <= 1'b1;
            o_wready <= 1'b0;
            wdata_q <= i_wdata;
            wstrb_q <= i_wstrb;
         end
         if (aw_q & w_q & ~o_bvalid)
         begin
            o_bvalid <= 1'b1;
            // Latched settings are fixed until next reset; option byte writes get OKAY but are ignored, other addresses get SLVERR
            o_bresp  <= (awaddr_q == optcfg_pkg::OPT_BYTE_ADDR) ? 2'b00 : 2'b10;
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
         end
         else if (o_bvalid & i_bready)
         begin
            // Both channels reopen only once the response is taken
            o_bvalid  <= 1'b0;
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
         end
      end
   end

   // Read: one cycle answer, unmapped gives SLVERR
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_rvalid  <= 1'b0;
         o_arready <= 1'b1;
         o_rdata   <= '0;
         o_rresp   <= 2'b00;
      end
      else if (i_arvalid & o_arready)
      begin
         o_rvalid  <= 1'b1;
         o_arready <= 1'b0;
         o_rresp   <= 2'b00;
         unique case (i_araddr)
            optcfg_pkg::OPT_BYTE_ADDR:
               o_rdata <= {24'h000000, {cfg_q[5:2], 2'b00, cfg_q[1:0]}
                           & optcfg_pkg::OPT_MASK};
            optcfg_pkg::CTRL_ADDR:
               o_rdata <= {30'h0, o_flash_blocked, o_flash_grant};
            optcfg_pkg::STAT_ADDR:
               o_rdata <= {16'h0000, phase_q, cnt_q};
            default:
            begin
               o_rdata <= '0;
               o_rresp <= 2'b10;
            end
         endcase
      end
      else if (o_rvalid & i_rready)
      begin
         o_rvalid  <= 1'b0;
         o_arready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   a_reset_held: assert property (@(posedge i_clk) disable iff (i_rst)
      phase_q == WAIT |=> o_sys_reset) else $error("reset dropped in wait");
   a_guard_blocks: assert property (@(posedge i_clk) disable iff (i_rst)
      blocked |=> !o_flash_grant) else $error("grant under guard");
   a_main_off_reset: assert property (@(posedge i_clk) disable iff (i_rst)
      (phase_q == WAIT && cfg_q.main_off) |=> !o_osc.main_xtal_en)
      else $error("main crystal on in reset");
   a_main_on_reset: assert property (@(posedge i_clk) disable iff (i_rst)
      !cfg_q.main_off |=> o_osc.main_xtal_en) else $error("main crystal off");
   a_aux_off_reset: assert property (@(posedge i_clk) disable iff (i_rst)
      (phase_q == WAIT && cfg_q.aux_off) |=> !o_osc.aux_osc_en)
      else $error("aux osc on in reset");
   a_aux_on_reset: assert property (@(posedge i_clk) disable iff (i_rst)
      !cfg_q.aux_off |=> o_osc.aux_osc_en) else $error("aux osc off");
   a_aux_mode_fol: assert property (@(posedge i_clk) disable iff (i_rst)
      1'b1 |=> o_osc.aux_xtal_mode == $past(cfg_q.aux_type))
      else $error("aux mode mismatch");
   a_cfg_stable: assert property (@(posedge i_clk) disable iff (i_rst)
      phase_q != LOAD |=> $stable(cfg_q)) else $error("config changed");
   // Last waiting cycle followed by the first running cycle
   sequence s_wait_done;
      (phase_q == WAIT) ##1 (phase_q == RUN);
   endsequence
   a_wait_length: assert property (@(posedge i_clk) disable iff (i_rst)
      s_wait_done |-> cnt_q == target) else $error("wait length wrong");
   a_grant_locks: assert property (@(posedge i_clk) disable iff (i_rst)
      o_flash_grant |-> $past(i_ctl_unlocked && i_sector_open))
      else $error("grant without locks");
endmodule : flash_option_reset_config

// ==== flash_option_reset_config_test.sv ====
/*
 Testbench for flash_option_reset_config: boots every wait code, checks
 oscillator steering, flash gating and AXI4-Lite access.
 Assumes the 50 ns system clock and a bench-made oscillator tick.
*/
`timescale 1ns/1ns
module flash_option_reset_config_test;
   // ----------------------------------------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------------------------------------
   logic                 i_clk = 1'b0;
   logic                 i_rst = 1'b1;
   logic                 i_osc_tick = 1'b0;
   logic [7:0]           i_flash_opt_byte = 8'h00;
   logic                 i_low_voltage = 1'b0;
   logic                 i_flash_req = 1'b0;
   logic                 i_ctl_unlocked = 1'b0;
   logic                 i_sector_open = 1'b0;
   logic                 i_awvalid = 1'b0;
   logic                 i_wvalid = 1'b0;
   logic                 i_bready = 1'b0;
   logic                 i_arvalid = 1'b0;
   logic                 i_rready = 1'b0;
   logic [7:0]           i_awaddr = 8'h00;
   logic [7:0]           i_araddr = 8'h00;
   logic [31:0]          i_wdata = 32'h0;
   logic                 o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic [1:0]           o_bresp, o_rresp, tdiv = 2'h0, r;
   logic [31:0]          o_rdata, d;
   logic                 o_sys_reset, o_flash_grant, o_flash_blocked;
   optcfg_pkg::osc_ctl_t o_osc;
   int                   fails = 0, cmp_count = 0, rises = 0;
   flash_option_reset_config flash_option_reset_config_i
   (
      .i_clk(i_clk), .i_rst(i_rst), .i_flash_opt_byte(i_flash_opt_byte),
      .i_osc_tick(i_osc_tick), .i_low_voltage(i_low_voltage), .i_flash_req(i_flash_req),
      .i_ctl_unlocked(i_ctl_unlocked), .i_sector_open(i_sector_open),
      .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr),
      .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(4'hF),
      .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
      .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
      .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
      .o_sys_reset(o_sys_reset), .o_osc(o_osc), .o_flash_grant(o_flash_grant),
      .o_flash_blocked(o_flash_blocked)
   );
   // Clock of 50 ns
   always #25 i_clk = ~i_clk;
   // Oscillator tick of four clocks, rises counted outside reset
   always @(posedge i_clk)
   begin
      tdiv <= tdiv + 2'h1;
      i_osc_tick <= tdiv[1];
      if (i_rst) rises <= 0;
      else if (tdiv[1] && !i_osc_tick) rises <= rises + 1;
   end
   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task end_sim;
      if (fails == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim
   // Write: both channels offered together, each released once taken
   task axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      int n;
      logic b_t;
      b_t = 1'b0;
      @(posedge i_clk);
      i_awaddr <= a;
      i_wdata <= v;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      for (n = 0; n < 50 && !b_t; n++)
      begin
         // Values read here are those the design sampled at this edge
         @(posedge i_clk);
         if (i_awvalid && o_awready) i_awvalid <= 1'b0;
         if (i_wvalid && o_wready) i_wvalid <= 1'b0;
         if (o_bvalid === 1'b1)
         begin
            b_t = 1'b1;
            rs = o_bresp;
         end
      end
      i_bready <= 1'b0;
      if (!b_t) fails++;
   endtask : axi_write
   // Read: address held until taken, rready held until the answer
   task axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      int n;
      logic r_t;
      r_t = 1'b0;
      @(posedge i_clk);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      for (n = 0; n < 50 && !r_t; n++)
      begin
         // Data is taken at the same edge that sees rvalid high
         @(posedge i_clk);
         if (i_arvalid && o_arready) i_arvalid <= 1'b0;
         if (o_rvalid === 1'b1)
         begin
            r_t = 1'b1;
            v = o_rdata;
            rs = o_rresp;
         end
      end
      i_rready <= 1'b0;
      if (!r_t) fails++;
   endtask : axi_read
   // ----------------------------------------------------------------------
   // Scenario: boot with one option byte, then flash gating
   // ----------------------------------------------------------------------
   task run_boot(input logic [7:0] ob);
      int n, lim;
      lim = (ob[7:6] == 2'b00) ? optcfg_pkg::WAIT_500 : (ob[7:6] == 2'b01) ?
            optcfg_pkg::WAIT_1000 : (ob[7:6] == 2'b10) ? optcfg_pkg::WAIT_5000 :
            optcfg_pkg::WAIT_10000;
      @(posedge i_clk);
      i_flash_opt_byte <= ob;
      i_rst <= 1'b1;
      i_flash_req <= 1'b1;
      i_ctl_unlocked <= 1'b1;
      i_sector_open <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (8) @(negedge i_clk);
      chk(o_sys_reset, 1'b1);
      chk(o_flash_grant, 1'b0);
      chk(o_osc.main_xtal_en, !ob[4]);
      chk(o_osc.aux_osc_en, !ob[0]);
      chk(o_osc.aux_xtal_mode, ob[1]);
      for (n = 0; n < 45000 && o_sys_reset === 1'b1; n++) @(negedge i_clk);
      chk(rises >= lim - 1 && rises <= lim + 2, 1'b1);
      chk(o_osc, {2'b11, ob[1]});
      axi_read(optcfg_pkg::OPT_BYTE_ADDR, d, r);
      chk(d, {24'h0, ob & optcfg_pkg::OPT_MASK});
      chk(r, 2'h0);
      i_low_voltage <= 1'b1;
      i_flash_req <= 1'b1;
      i_ctl_unlocked <= 1'b1;
      i_sector_open <= 1'b1;
      repeat (6) @(negedge i_clk);
      chk(o_flash_blocked, ob[5]);
      chk(o_flash_grant, !ob[5]);
      @(posedge i_clk);
      i_low_voltage <= 1'b0;
      i_sector_open <= 1'b0;
      repeat (6) @(negedge i_clk);
      chk(o_flash_grant, 1'b0);
      @(posedge i_clk);
      i_sector_open <= 1'b1;
      repeat (6) @(negedge i_clk);
      chk({o_flash_blocked, o_flash_grant}, 2'b01);
      @(posedge i_clk);
      i_ctl_unlocked <= 1'b0;
      repeat (6) @(negedge i_clk);
      chk(o_flash_grant, 1'b0);
      @(posedge i_clk);
      i_flash_req <= 1'b0;
      i_ctl_unlocked <= 1'b1;
   endtask : run_boot
   // ----------------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------------
   initial
   begin
      repeat (4) @(posedge i_clk);
      i_rst <= 1'b0;
      run_boot(8'h0C);
      run_boot(8'h53);
      run_boot(8'hA2);
      run_boot(8'hF1);
      i_low_voltage <= 1'b1;
      axi_write(optcfg_pkg::OPT_BYTE_ADDR, 32'hFFFFFFFF, r);
      chk(r, 2'h0);
      axi_write(8'h10, 32'h0000005A, r);
      chk(r, 2'h2);
      axi_read(8'h10, d, r);
      chk(d, 32'h0);
      chk(r, 2'h2);
      axi_read(optcfg_pkg::OPT_BYTE_ADDR, d, r);
      chk(d, 32'h000000F1);
      axi_read(optcfg_pkg::CTRL_ADDR, d, r);
      chk(d, 32'h00000002);
      axi_read(optcfg_pkg::STAT_ADDR, d, r);
      chk(d[13:0], optcfg_pkg::WAIT_10000);
      end_sim;
   end
   // Cuts a hang short well past the expected run length
   initial
   begin
      #4500000;
      fails++;
      end_sim;
   end
endmodule : flash_option_reset_config_test
